// ===== rtl/rcg_divider.sv
// divider: toggles its level every div ticks of the selected source
// assumes tick is a one-cycle enable; load is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module rcg_divider #(
  parameter int DW = 15
) (
  input  wire logic          clk_sys,   // system clock
  input  wire logic          rst_n,     // async reset, low
  input  wire logic          run,       // generator running
  input  wire logic          tick,      // source enable
  input  wire logic [DW-1:0] div_in,    // new divider value
  input  wire logic          load,      // request divider switch
  output logic               lvl,       // divided clock level
  output logic               done       // switch completed pulse
);

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic [DW-1:0] div;
    logic          lvl;
    logic          pend;
    logic          done;
  } rcg_div_st_t;

  rcg_div_st_t s_q;
  rcg_div_st_t s_d;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (load) begin
      s_d.pend = 1'b1;
    end
    if (!run) begin
      s_d.cnt = '0;
      s_d.lvl = 1'b0;
      if (s_d.pend) begin
        s_d.div  = div_in;
        s_d.pend = 1'b0;
        s_d.done = 1'b1;
      end
    end else if (tick) begin
      if ({1'b0, s_q.cnt} + (DW+1)'(1) >= {1'b0, s_q.div}) begin
        s_d.cnt = '0;
        s_d.lvl = ~s_q.lvl;
        // while running, new ratio only at a half-period edge, so no runt pulse
        if (s_d.pend) begin
          s_d.div  = div_in;
          s_d.pend = 1'b0;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.cnt = s_q.cnt + DW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl  = s_q.lvl;
  assign done = s_q.done;

endmodule : rcg_divider
`default_nettype wire

// ===== rtl/rcg_pkg.sv
// constants for the reference clock generator control block
// assumes a 32-bit Avalon-MM register slave and one system clock
package rcg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL_OFS  = 4'h0;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int          DIV_LSB       = 16;
  localparam int          DIV_MSB       = 30;
  localparam int          DIV_W         = 15;
  localparam int          ON_BIT        = 15;
  localparam int          STOP_IN_IDLE_BIT      = 13;
  localparam int          OE_BIT        = 12;
  localparam int          RUN_IN_SLEEP_BIT      = 11;
  localparam int          DIVSW_BIT     = 9;
  localparam int          ACTIVE_BIT    = 8;
  localparam int          SEL_LSB       = 0;
  localparam int          SEL_W         = 4;
  localparam logic [3:0]  SEL_NO_RUN_IN_SLEEP_0 = 4'h0;
  localparam logic [3:0]  SEL_NO_RUN_IN_SLEEP_1 = 4'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] DIV_RST       = 15'h0000;
  localparam logic [3:0]  SEL_RST       = 4'h0;
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

endpackage : rcg_pkg

// ===== rtl/rcg_src_sel.sv
// source selector: picks one of the source tick enables
// assumes each source is a one-cycle enable pulse on clk_sys
`timescale 1ns/1ps
`default_nettype none
module rcg_src_sel #(
  parameter int N_SRC = 16
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             rst_n,     // async reset, low
  input  wire logic [N_SRC-1:0] src_tick,  // source enables
  input  wire logic [3:0]       sel,       // source index
  output logic                  tick       // selected enable
);

  typedef struct packed {
    logic tick;
  } rcg_sel_st_t;

  rcg_sel_st_t s_q;
  rcg_sel_st_t s_d;

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // absent sources read as never ticking
    s_d.tick = (32'(sel) < N_SRC) ? src_tick[sel] : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : rcg_src_sel
`default_nettype wire

// ===== rtl/rcg_top.sv
// reference clock generator control: register slave, run gating, pin
// assumes Avalon-MM master on clk_sys, idle/sleep levels from the core
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcg_top #(
  parameter int N_SRC = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_sys,            // system clock, 200 MHz
  input  wire logic             rst_n,              // async reset, low
  input  wire logic [AW-1:0]    avs_address,        // word address
  input  wire logic             avs_read,           // read request
  input  wire logic             avs_write,          // write request
  input  wire logic [31:0]      avs_writedata,      // write data
  input  wire logic [3:0]       avs_byteenable,     // byte lanes
  output logic [31:0]           avs_readdata,       // read data
  output logic                  avs_waitrequest,    // stall
  input  wire logic [N_SRC-1:0] src_tick,           // source clock enables
  input  wire logic             cpu_idle,           // device in Idle
  input  wire logic             cpu_sleep,          // device in Sleep
  output logic                  ref_clock_out_pin,  // reference clock pin
  output logic                  ref_clock_out_oe_n  // pin drive, low = driving
);

  typedef struct packed {
    logic [14:0] div;
    logic        on;
    logic        stop_in_idle;
    logic        oe;
    logic        run_in_sleep;
    logic        divsw;
    logic        active;
    logic [3:0]  sel;
    logic        load;
    logic        waitreq;
    logic [31:0] rdata;
    logic        pin;
    logic        pin_oe_n;
  } rcg_top_st_t;

  rcg_top_st_t s_q;
  rcg_top_st_t s_d;

  logic        sel_tick;
  logic        div_lvl;
  logic        div_done;
  logic        run;
  logic        run_in_sleep_eff;
  logic        req;
  logic        hit;
  logic [31:0] img;
  logic [31:0] bmask;
  logic [31:0] nw;

  // ----------------------------------------------------------------
  // source and divider
  // ----------------------------------------------------------------
  // source select
  rcg_src_sel #(
    .N_SRC (N_SRC)
  ) u_sel (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .src_tick (src_tick),
    .sel      (s_q.sel),
    .tick     (sel_tick)
  );

  rcg_divider #(
    .DW (rcg_pkg::DIV_W)
  ) u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (run),
    .tick    (sel_tick),
    .div_in  (s_q.div),
    .load    (s_q.load),
    .lvl     (div_lvl),
    .done    (div_done)
  );

  // ----------------------------------------------------------------
  // run gating
  // ----------------------------------------------------------------
  always_comb begin
    run_in_sleep_eff = s_q.run_in_sleep && (s_q.sel != rcg_pkg::SEL_NO_RUN_IN_SLEEP_0)
                        && (s_q.sel != rcg_pkg::SEL_NO_RUN_IN_SLEEP_1);
    run = s_q.on && !(cpu_idle && s_q.stop_in_idle) && !(cpu_sleep && !run_in_sleep_eff);
  end

  // ----------------------------------------------------------------
  // register image and write merge
  // ----------------------------------------------------------------
  always_comb begin
    img = '0;
    img[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB]                 = s_q.div;
    img[rcg_pkg::ON_BIT]                                   = s_q.on;
    img[rcg_pkg::STOP_IN_IDLE_BIT]                                 = s_q.stop_in_idle;
    img[rcg_pkg::OE_BIT]                                   = s_q.oe;
    img[rcg_pkg::RUN_IN_SLEEP_BIT]                                 = s_q.run_in_sleep;
    img[rcg_pkg::DIVSW_BIT]                                = s_q.divsw;
    img[rcg_pkg::ACTIVE_BIT]                               = s_q.active;
    img[rcg_pkg::SEL_LSB+rcg_pkg::SEL_W-1:rcg_pkg::SEL_LSB] = s_q.sel;
    bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    nw    = (img & ~bmask) | (avs_writedata & bmask);
    req   = avs_read || avs_write;
    hit   = (avs_address == AW'(rcg_pkg::REG_CTRL_OFS));
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.load = 1'b0;
    if (div_done) begin
      s_d.divsw = 1'b0;
    end
    if (req && s_q.waitreq) begin
      // first cycle: prepare the answer, release the stall
      s_d.waitreq = 1'b0;
      s_d.rdata   = (avs_read && hit) ? img : rcg_pkg::RDATA_RST;
    end else begin
      s_d.waitreq = 1'b1;
      if (req && avs_write && hit) begin
        s_d.on   = nw[rcg_pkg::ON_BIT];
        s_d.stop_in_idle = nw[rcg_pkg::STOP_IN_IDLE_BIT];
        s_d.oe   = nw[rcg_pkg::OE_BIT];
        s_d.run_in_sleep = nw[rcg_pkg::RUN_IN_SLEEP_BIT];
        s_d.sel  = nw[rcg_pkg::SEL_LSB+rcg_pkg::SEL_W-1:rcg_pkg::SEL_LSB];
        s_d.div  = nw[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB];
        if (nw[rcg_pkg::DIVSW_BIT]) begin
          // software sets, hardware clears; a set beats a done
          s_d.divsw = 1'b1;
          s_d.load  = 1'b1;
        end else if (!s_q.on && (s_d.div != s_q.div)) begin
          s_d.load = 1'b1;
        end
      end
    end
    s_d.active   = run;
    // pin output enable; pin_oe_n high (not driving) and pin low when off
    s_d.pin      = s_q.on && s_q.oe && div_lvl;
    s_d.pin_oe_n = !(s_q.on && s_q.oe);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.div      <= rcg_pkg::DIV_RST;
      s_q.sel      <= rcg_pkg::SEL_RST;
      s_q.rdata    <= rcg_pkg::RDATA_RST;
      s_q.waitreq  <= 1'b1;
      s_q.pin_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata       = s_q.rdata;
  assign avs_waitrequest    = s_q.waitreq;
  assign ref_clock_out_pin  = s_q.pin;
  assign ref_clock_out_oe_n = s_q.pin_oe_n;

endmodule : rcg_top
`default_nettype wire

// ===== test/rcg_top_sva.sv
// assertions for the reference clock control block
// assumes binding to rcg_top; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module rcg_top_sva #(
  parameter int N_SRC = 16,
  parameter int AW    = 4
) (
  input wire logic             clk_sys,           // clock
  input wire logic             rst_n,             // reset
  input wire logic [AW-1:0]    avs_address,       // address
  input wire logic             avs_read,          // read
  input wire logic             avs_write,         // write
  input wire logic [31:0]      avs_writedata,     // wdata
  input wire logic [3:0]       avs_byteenable,    // lanes
  input wire logic [31:0]      avs_readdata,      // rdata
  input wire logic             avs_waitrequest,   // stall
  input wire logic [N_SRC-1:0] src_tick,          // ticks
  input wire logic             cpu_idle,          // idle
  input wire logic             cpu_sleep,         // sleep
  input wire logic             ref_clock_out_pin, // pin
  input wire logic             ref_clock_out_oe_n // drive
);
  localparam logic [31:0] WM = 32'h7FFF_B80F;
  logic [31:0] ctl_q;
  logic [2:0]  off_q;
  logic [2:0]  on_q;
  logic [2:0]  wr_q;
  logic        run;
  logic        wr;
  logic        rd;
  assign wr = avs_write && !avs_waitrequest && avs_address == '0;
  assign rd = avs_read && !avs_waitrequest && avs_address == '0;
  // sources 0/1 always stop in sleep
  assign run = ctl_q[15] && !(cpu_idle && ctl_q[13])
               && !(cpu_sleep && !(ctl_q[11] && ctl_q[3:1] != 3'h0));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 32'h0000_0000;
      off_q <= 3'h7;
      on_q  <= 3'h0;
      wr_q  <= 3'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wr && avs_byteenable[b]) begin
          ctl_q[8*b+:8] <= avs_writedata[8*b+:8] & WM[8*b+:8];
        end
      end
      off_q <= run ? 3'h0 : off_q + 3'(off_q != 3'h7);
      on_q  <= !run ? 3'h0 : on_q + 3'(on_q != 3'h7);
      wr_q  <= wr ? 3'h0 : wr_q + 3'(wr_q != 3'h7);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_stop_pin: assert property (
    off_q == 3'h7 |-> !ref_clock_out_pin) else $error("pin active while stopped");
  chk_toggle_run: assert property (
    $changed(ref_clock_out_pin) |-> off_q < 3'h6) else $error("pin toggled while stopped");
  chk_oe_follow: assert property (
    wr_q == 3'h7 |-> ref_clock_out_oe_n == !(ctl_q[15] && ctl_q[12]))
    else $error("pin drive wrong");
  chk_reserved_zero: assert property (
    !avs_waitrequest |-> (avs_readdata & 32'h8000_44F0) == '0) else $error("reserved bit set");
  chk_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address != '0 |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (
    rd |-> (avs_readdata & WM) == ctl_q) else $error("control readback wrong");
  chk_active_on: assert property (
    rd && on_q == 3'h7 |-> avs_readdata[8]) else $error("active bit low");
  chk_active_off: assert property (
    rd && off_q == 3'h7 |-> !avs_readdata[8]) else $error("active bit high");
endmodule : rcg_top_sva
bind rcg_top rcg_top_sva #(.N_SRC(N_SRC), .AW(AW)) i_rcg_top_sva (.clk_sys, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .src_tick, .cpu_idle, .cpu_sleep, .ref_clock_out_pin, .ref_clock_out_oe_n);
`default_nettype wire

// ===== test/rcg_top_test.sv
// self-checking bench for the reference clock control block
// assumes rcg_top with default parameters at 200 MHz
`timescale 1ns/1ps
`default_nettype none
module rcg_top_test;
  logic        clk_sys, rst_n, avs_read, avs_write, cpu_idle, cpu_sleep, all_ticks, pin_d;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd_q, mdl, exp_q[$], msk_q[$];
  logic [15:0] src_tick;
  logic        avs_waitrequest, ref_clock_out_pin, ref_clock_out_oe_n;
  int          failures, num_checks, cyc, last_rise, per;
  int          seed = 95;
  rcg_top i_rcg_top (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .src_tick, .cpu_idle, .cpu_sleep,
    .ref_clock_out_pin, .ref_clock_out_oe_n);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // one access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check("readdata", avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    cyc++;
    if (ref_clock_out_pin === 1'b1 && pin_d === 1'b0) begin
      per = cyc - last_rise;
      last_rise = cyc;
    end
    pin_d = ref_clock_out_pin;
    src_tick <= all_ticks ? 16'hFFFF : 16'($random(seed));
  end
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
  initial begin : main
    logic [31:0] d;
    logic        run;
    {rst_n, avs_read, avs_write, cpu_idle, cpu_sleep, all_ticks} = 6'h00;
    {avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
    mdl = '0;
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      // enable byte only: source and divider stay put while still active
      avs_byteenable <= 4'h2;
      bus(1'b1, 4'h0, 32'h0000_0000); // stop before new source
      avs_byteenable <= d[27:24] | 4'h2;
      cpu_idle  <= d[5];
      cpu_sleep <= d[6];
      bus(1'b1, 4'h0, d);
      mdl[15:8] = 8'h00;
      for (int b = 0; b < 4; b++) if (d[24+b] || b == 1) mdl[8*b+:8] = d[8*b+:8];
      mdl &= 32'h7FFF_B80F;
      run = mdl[15] && !(d[5] && mdl[13]) && !(d[6] && !(mdl[11] && mdl[3:1] != 3'h0));
      bus(1'b1, 4'h3, 32'hFFFF_FFFF);
      rd(4'h3, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(4'h0, mdl | {23'h0, run, 8'h0}, 32'hFFFF_FDFF);
    end
    cpu_idle  <= 1'b0;
    cpu_sleep <= 1'b0;
    all_ticks <= 1'b1;
    avs_byteenable <= 4'h2;
    bus(1'b1, 4'h0, 32'h0000_0000); // stop before new divider
    avs_byteenable <= 4'hF;
    bus(1'b1, 4'h0, 32'h0003_1002);
    bus(1'b1, 4'h0, 32'h0003_9002);
    repeat (40) @(posedge clk_sys);
    check("period", per, 6);
    bus(1'b1, 4'h0, 32'h0005_9002);
    repeat (40) @(posedge clk_sys);
    check("period_held", per, 6);
    bus(1'b1, 4'h0, 32'h0005_9202);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check("switch_busy", rd_q[9], 1'b1);
    for (int n = 0; n < 20 && rd_q[9] !== 1'b0; n++) bus(1'b0, 4'h0, 32'h0000_0000);
    check("switch_done", rd_q[9], 1'b0);
    repeat (40) @(posedge clk_sys);
    check("period_new", per, 10);
    bus(1'b1, 4'h0, 32'h0005_8002);
    repeat (20) @(posedge clk_sys);
    check("pin_off", {ref_clock_out_oe_n, ref_clock_out_pin}, 2'b10);
    give_verdict();
  end
endmodule : rcg_top_test
`default_nettype wire
